// ---- rtl/cds_top.sv ----
// serial control port, global registers and sync control
module cds_top
    import cds_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic serial_clk,
    input wire logic serial_chip_select_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    input wire logic sync_pin,
    output logic divider_sync_pulse,
    output logic sync_buffer_enable,
    output logic [CDS_DATA_W-1:0] test_pattern_three_high,
    output logic [CDS_DATA_W-1:0] test_pattern_four_low
);
    logic [CDS_SYNC_FIELD_W-1:0] sync_control;
    logic sclk_meta;
    logic sclk_stable;
    logic sclk_prev;
    logic csn_meta;
    logic csn_stable;
    logic sdi_meta;
    logic sdi_stable;
    logic sclk_rise;
    logic sclk_fall;
    cds_state_e state;
    logic [CDS_CNT_W-1:0] bit_cnt;
    logic [CDS_INSTR_BITS-2:0] instr_shift;
    logic [CDS_DATA_W-2:0] data_shift;
    logic [CDS_DATA_W-1:0] read_shift;
    logic [CDS_ADDR_W-1:0] addr;
    logic is_read;
    logic instr_done;
    logic byte_done;
    logic reg_wr;
    logic [CDS_DATA_W-1:0] wr_data;
    logic [CDS_ADDR_W-1:0] next_addr;
    logic [CDS_INSTR_BITS-1:0] instr_word;
    logic sync_wr;
    logic clear_req;

    function automatic logic [CDS_DATA_W-1:0] reg_read(
        input logic [CDS_ADDR_W-1:0] a,
        input logic [CDS_DATA_W-1:0] p3h,
        input logic [CDS_DATA_W-1:0] p4l,
        input logic [CDS_SYNC_FIELD_W-1:0] sc
    );
        logic [CDS_DATA_W-1:0] r;
        r = CDS_READ_ZERO;
        if (a == CDS_ADDR_PAT3_HIGH) begin
            r = p3h;
        end else if (a == CDS_ADDR_PAT4_LOW) begin
            r = p4l;
        end else if (a == CDS_ADDR_SYNC_CTRL) begin
            r = {{(CDS_DATA_W-CDS_SYNC_FIELD_W){1'b0}}, sc};
        end
        return r;
    endfunction : reg_read

    // pin synchronisers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sclk_meta <= 1'b0;
            sclk_stable <= 1'b0;
            sclk_prev <= 1'b0;
            csn_meta <= 1'b1;
            csn_stable <= 1'b1;
            sdi_meta <= 1'b0;
            sdi_stable <= 1'b0;
        end else begin
            sclk_meta <= serial_clk;
            sclk_stable <= sclk_meta;
            sclk_prev <= sclk_stable;
            csn_meta <= serial_chip_select_n;
            csn_stable <= csn_meta;
            sdi_meta <= serial_data_in;
            sdi_stable <= sdi_meta;
        end
    end

    assign sclk_rise = sclk_stable & ~sclk_prev;
    assign sclk_fall = ~sclk_stable & sclk_prev;
    assign instr_word = {instr_shift, sdi_stable};
    assign instr_done = (state == CDS_ST_INSTR) && sclk_rise && (bit_cnt == CDS_INSTR_LAST);
    assign byte_done = (state == CDS_ST_DATA) && sclk_rise && (bit_cnt == CDS_BYTE_LAST);
    assign reg_wr = byte_done && !is_read;
    assign wr_data = {data_shift, sdi_stable};
    assign next_addr = instr_done ? instr_word[CDS_ADDR_W-1:0] : (addr - CDS_ADDR_ONE);
    assign sync_wr = reg_wr && (addr == CDS_ADDR_SYNC_CTRL);

    // frame sequencing
    always_ff @(posedge core_clk) begin
        if (reset || csn_stable) begin
            state <= CDS_ST_IDLE;
            bit_cnt <= CDS_CNT_ZERO;
        end else begin
            unique case (state)
                CDS_ST_IDLE: begin
                    state <= CDS_ST_INSTR;
                    bit_cnt <= CDS_CNT_ZERO;
                end
                CDS_ST_INSTR: begin
                    if (instr_done) begin
                        state <= CDS_ST_DATA;
                        bit_cnt <= CDS_CNT_ZERO;
                    end else if (sclk_rise) begin
                        bit_cnt <= bit_cnt + CDS_CNT_ONE;
                    end
                end
                CDS_ST_DATA: begin
                    if (byte_done) begin
                        bit_cnt <= CDS_CNT_ZERO;
                    end else if (sclk_rise) begin
                        bit_cnt <= bit_cnt + CDS_CNT_ONE;
                    end
                end
                default: begin
                    state <= CDS_ST_IDLE;
                    bit_cnt <= CDS_CNT_ZERO;
                end
            endcase
        end
    end

    // instruction and write data capture
    always_ff @(posedge core_clk) begin
        if (reset) begin
            instr_shift <= '0;
            data_shift <= '0;
            is_read <= 1'b0;
            addr <= '0;
        end else if (sclk_rise) begin
            if (state == CDS_ST_INSTR) begin
                instr_shift <= instr_word[CDS_INSTR_BITS-2:0];
            end
            if (state == CDS_ST_DATA) begin
                data_shift <= wr_data[CDS_DATA_W-2:0];
            end
            if (instr_done) begin
                is_read <= instr_word[CDS_INSTR_RW_BIT];
            end
            if (instr_done || byte_done) begin
                addr <= next_addr;
            end
        end
    end

    // read data drive, changes on falling clock
    always_ff @(posedge core_clk) begin
        if (reset || csn_stable) begin
            read_shift <= CDS_READ_ZERO;
            serial_data_out <= 1'b0;
            serial_data_oe <= 1'b0;
        end else if ((instr_done && instr_word[CDS_INSTR_RW_BIT]) || (byte_done && is_read)) begin
            read_shift <= reg_read(next_addr, test_pattern_three_high,
                                   test_pattern_four_low, sync_control);
        end else if (sclk_fall && (state == CDS_ST_DATA) && is_read) begin
            serial_data_out <= read_shift[CDS_DATA_W-1];
            serial_data_oe <= 1'b1;
            read_shift <= {read_shift[CDS_DATA_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            test_pattern_three_high <= CDS_RST_PAT3_HIGH;
            test_pattern_four_low <= CDS_RST_PAT4_LOW;
        end else if (reg_wr) begin
            if (addr == CDS_ADDR_PAT3_HIGH) begin
                test_pattern_three_high <= wr_data;
            end
            if (addr == CDS_ADDR_PAT4_LOW) begin
                test_pattern_four_low <= wr_data;
            end
        end
    end

    // sync control register, host write beats auto clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync_control <= CDS_RST_SYNC_CTRL;
        end else if (sync_wr) begin
            sync_control <= wr_data[CDS_SYNC_FIELD_W-1:0];
        end else if (clear_req) begin
            sync_control[CDS_BIT_DIV_EN] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync_buffer_enable <= 1'b0;
        end else begin
            sync_buffer_enable <= sync_control[CDS_BIT_MASTER_EN];
        end
    end

    cds_sync_gate u_sync_gate (
        .core_clk(core_clk),
        .reset(reset),
        .sync_pin(sync_pin),
        .master_en(sync_control[CDS_BIT_MASTER_EN]),
        .div_en(sync_control[CDS_BIT_DIV_EN]),
        .next_only(sync_control[CDS_BIT_NEXT_ONLY]),
        .divider_sync(divider_sync_pulse),
        .clear_req(clear_req)
    );

    property p_auto_clear;
        @(posedge core_clk) disable iff (reset)
        (clear_req && !sync_wr) |=> !sync_control[CDS_BIT_DIV_EN];
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("divider sync enable not cleared after one-shot sync");

    property p_one_shot;
        @(posedge core_clk) disable iff (reset)
        (clear_req && !sync_wr) |=> (!divider_sync_pulse)[*3];
    endproperty
    a_one_shot: assert property (p_one_shot)
        else $error("sync pulse passed after one-shot sync");

    property p_pattern_reset;
        @(posedge core_clk) disable iff (reset)
        $past(reset) |-> (test_pattern_three_high == CDS_RST_PAT3_HIGH)
            && (test_pattern_four_low == CDS_RST_PAT4_LOW);
    endproperty
    a_pattern_reset: assert property (p_pattern_reset)
        else $error("test pattern register not zero after reset");

    property p_pattern_write;
        @(posedge core_clk) disable iff (reset)
        (reg_wr && addr == CDS_ADDR_PAT3_HIGH) |=> (test_pattern_three_high == $past(wr_data));
    endproperty
    a_pattern_write: assert property (p_pattern_write)
        else $error("test pattern write not stored");

    property p_reserved_zero;
        @(posedge core_clk) disable iff (reset)
        (reg_wr && addr == CDS_ADDR_SYNC_CTRL) |=>
            (reg_read(CDS_ADDR_SYNC_CTRL, test_pattern_three_high, test_pattern_four_low,
                      sync_control) == {{(CDS_DATA_W-CDS_SYNC_FIELD_W){1'b0}},
                                        $past(wr_data[CDS_SYNC_FIELD_W-1:0])});
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("sync control upper bits not zero");

    property p_buffer_off;
        @(posedge core_clk) disable iff (reset)
        !sync_control[CDS_BIT_MASTER_EN] |=> !sync_buffer_enable && !divider_sync_pulse;
    endproperty
    a_buffer_off: assert property (p_buffer_off)
        else $error("sync active without master enable");
endmodule : cds_top

// ---- inc/cds_pkg.sv ----
// constants for the clock divider sync control block
// Summary of operation
// - no sync action unless master enable set
// - pulses pass only with both enables set
// - next-sync-only takes first pulse, ignores rest
// - device clears divider sync enable after syncing in next-sync-only mode
// - test pattern bytes separate, reset to zero
package cds_pkg;
    localparam int CDS_ADDR_W = 13;
    localparam int CDS_DATA_W = 8;
    localparam int CDS_INSTR_BITS = 16;
    localparam int CDS_CNT_W = 4;
    localparam logic [CDS_CNT_W-1:0] CDS_INSTR_LAST = 4'hF;
    localparam logic [CDS_CNT_W-1:0] CDS_BYTE_LAST = 4'h7;
    localparam logic [CDS_CNT_W-1:0] CDS_CNT_ZERO = 4'h0;
    localparam logic [CDS_CNT_W-1:0] CDS_CNT_ONE = 4'h1;
    localparam logic [CDS_ADDR_W-1:0] CDS_ADDR_ONE = 13'h0001;

    // register offsets
    localparam logic [CDS_ADDR_W-1:0] CDS_ADDR_PAT3_HIGH = 13'h001E;
    localparam logic [CDS_ADDR_W-1:0] CDS_ADDR_PAT4_LOW = 13'h001F;
    localparam logic [CDS_ADDR_W-1:0] CDS_ADDR_SYNC_CTRL = 13'h003A;

    // reset values
    localparam logic [CDS_DATA_W-1:0] CDS_RST_PAT3_HIGH = 8'h00;
    localparam logic [CDS_DATA_W-1:0] CDS_RST_PAT4_LOW = 8'h00;
    localparam logic [2:0] CDS_RST_SYNC_CTRL = 3'h0;
    localparam logic [CDS_DATA_W-1:0] CDS_READ_ZERO = 8'h00;

    // sync control field positions
    localparam int CDS_BIT_MASTER_EN = 0;
    localparam int CDS_BIT_DIV_EN = 1;
    localparam int CDS_BIT_NEXT_ONLY = 2;
    localparam int CDS_SYNC_FIELD_W = 3;

    // instruction word layout
    localparam int CDS_INSTR_RW_BIT = 15;

    typedef enum logic [2:0] {
        CDS_ST_IDLE = 3'b001,
        CDS_ST_INSTR = 3'b010,
        CDS_ST_DATA = 3'b100
    } cds_state_e;
endpackage : cds_pkg

// ---- rtl/cds_sync_gate.sv ----
// sync pin synchroniser and gate towards the clock divider
module cds_sync_gate
    import cds_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sync_pin,
    input wire logic master_en,
    input wire logic div_en,
    input wire logic next_only,
    output logic divider_sync,
    output logic clear_req
);
    logic sync_meta;
    logic sync_stable;
    logic sync_prev;
    logic sync_edge;

    // two-flop synchroniser, then edge history
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync_meta <= 1'b0;
            sync_stable <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            sync_meta <= sync_pin;
            sync_stable <= sync_meta;
            sync_prev <= sync_stable;
        end
    end

    assign sync_edge = sync_stable & ~sync_prev;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            divider_sync <= 1'b0;
        end else begin
            divider_sync <= sync_edge & master_en & div_en;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            clear_req <= 1'b0;
        end else begin
            clear_req <= sync_edge & master_en & div_en & next_only;
        end
    end

    property p_master_needed;
        @(posedge core_clk) disable iff (reset)
        divider_sync |-> $past(master_en);
    endproperty
    a_master_needed: assert property (p_master_needed)
        else $error("divider sync without master enable");

    property p_edge_passes;
        @(posedge core_clk) disable iff (reset)
        (sync_edge && master_en && div_en) |=> divider_sync;
    endproperty
    a_edge_passes: assert property (p_edge_passes)
        else $error("enabled sync edge not passed to divider");

    property p_gated_off;
        @(posedge core_clk) disable iff (reset)
        (sync_edge && !(master_en && div_en)) |=> !divider_sync;
    endproperty
    a_gated_off: assert property (p_gated_off)
        else $error("sync edge passed while gated off");
endmodule : cds_sync_gate

// ---- tb/cds_host_model.sv ----
// serial control port host model for the sync control block
module cds_host_model (
    input wire logic core_clk,
    input wire logic sdio,
    output logic serial_clk,
    output logic serial_chip_select_n,
    output logic host_bit,
    output logic host_oe,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        serial_clk = 1'b0;
        serial_chip_select_n = 1'b1;
        host_bit = 1'b0;
        host_oe = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_cyc

    task automatic frame(input logic rw, input logic [12:0] addr, input int nbits,
                         input logic [15:0] wdata);
        logic [15:0] instr;
        logic [7:0] sh;
        instr = {rw, 2'b00, addr};
        sh = 8'h00;
        @(negedge core_clk);
        serial_chip_select_n = 1'b0;
        host_oe = 1'b1;
        wait_cyc(4);
        for (int i = 0; i < 16 + nbits; i++) begin
            serial_clk = 1'b0;
            if (i < 16)
                host_bit = instr[15-i];
            else if (rw)
                host_oe = 1'b0;
            else
                host_bit = wdata[nbits-1-(i-16)];
            wait_cyc(6);
            serial_clk = 1'b1;
            wait_cyc(6);
            if (rw && i >= 16) begin
                sh = {sh[6:0], sdio};
                if (((i - 16) % 8) == 7) begin
                    rd_data = sh;
                    rd_valid = 1'b1;
                    wait_cyc(1);
                    rd_valid = 1'b0;
                end
            end
        end
        serial_clk = 1'b0;
        wait_cyc(6);
        serial_chip_select_n = 1'b1;
        host_oe = 1'b0;
        wait_cyc(10);
    endtask : frame
endmodule : cds_host_model

// ---- tb/cds_top_test.sv ----
// self-checking bench for the sync control block
module cds_top_test
    import cds_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset, serial_clk, serial_chip_select_n, serial_data_in;
    logic serial_data_out, serial_data_oe, sync_pin, divider_sync_pulse;
    logic sync_buffer_enable, host_bit, host_oe, rd_valid;
    logic [7:0] rd_data, test_pattern_three_high, test_pattern_four_low, pulse_cnt, p3, p4;
    logic [7:0] exp_q[$];
    logic [31:0] rng;
    int num_errors, cmp_count, cycles;

    assign serial_data_in = serial_data_oe ? serial_data_out : (host_oe ? host_bit : ~host_bit);

    cds_top dut (.core_clk(core_clk), .reset(reset), .serial_clk(serial_clk),
        .serial_chip_select_n(serial_chip_select_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
        .sync_pin(sync_pin), .divider_sync_pulse(divider_sync_pulse),
        .sync_buffer_enable(sync_buffer_enable),
        .test_pattern_three_high(test_pattern_three_high),
        .test_pattern_four_low(test_pattern_four_low));

    cds_host_model host (.core_clk(core_clk), .sdio(serial_data_in), .serial_clk(serial_clk),
        .serial_chip_select_n(serial_chip_select_n), .host_bit(host_bit), .host_oe(host_oe),
        .rd_valid(rd_valid), .rd_data(rd_data));

    always #20 core_clk = ~core_clk;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xorshift

    task automatic end_of_test();
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask : check

    task automatic wr(input logic [12:0] a, input int nbits, input logic [15:0] d);
        host.frame(1'b0, a, nbits, d);
    endtask : wr

    task automatic rd(input logic [12:0] a, input int n, input logic [7:0] e0,
                      input logic [7:0] e1);
        exp_q.push_back(e0);
        if (n > 1)
            exp_q.push_back(e1);
        host.frame(1'b1, a, 8 * n, 16'h0000);
    endtask : rd

    task automatic pulse();
        @(negedge core_clk);
        sync_pin = 1'b1;
        repeat (3) @(negedge core_clk);
        sync_pin = 1'b0;
        repeat (8) @(negedge core_clk);
    endtask : pulse

    always @(posedge core_clk) begin
        cycles++;
        if (reset)
            pulse_cnt <= 8'h00;
        else if (divider_sync_pulse === 1'b1)
            pulse_cnt <= pulse_cnt + 8'h01;
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0)
                check("unexpected read", 8'h00, 8'hFF);
            else
                check("read byte", exp_q.pop_front(), rd_data);
        end
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        sync_pin = 1'b0;
        rng = 32'h00000043;
        num_errors = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        check("pattern three high", CDS_RST_PAT3_HIGH, test_pattern_three_high);
        check("pattern four low", CDS_RST_PAT4_LOW, test_pattern_four_low);
        rd(CDS_ADDR_PAT4_LOW, 2, 8'h00, 8'h00);
        rd(CDS_ADDR_SYNC_CTRL, 1, 8'h00, 8'h00);
        rng = xorshift(rng);
        p4 = rng[7:0];
        p3 = rng[15:8];
        wr(CDS_ADDR_PAT4_LOW, 16, {p4, p3});
        check("pattern three high", p3, test_pattern_three_high);
        check("pattern four low", p4, test_pattern_four_low);
        rd(CDS_ADDR_PAT4_LOW, 2, p4, p3);
        wr(CDS_ADDR_PAT3_HIGH, 4, ~{8'h00, p3});
        check("aborted write", p3, test_pattern_three_high);
        wr(13'h0005, 8, 16'h0003);
        wr(13'h0000, 8, {8'h00, rng[23:16]});
        rd(13'h0000, 1, CDS_READ_ZERO, 8'h00);
        wr(CDS_ADDR_SYNC_CTRL, 8, 16'h0002);
        check("buffer enable", 8'h00, {7'h00, sync_buffer_enable});
        pulse();
        check("pulses", 8'h00, pulse_cnt);
        wr(CDS_ADDR_SYNC_CTRL, 8, 16'h0003);
        check("buffer enable", 8'h01, {7'h00, sync_buffer_enable});
        pulse();
        pulse();
        check("pulses", 8'h02, pulse_cnt);
        wr(CDS_ADDR_SYNC_CTRL, 8, 16'h00FF);
        rd(CDS_ADDR_SYNC_CTRL, 1, 8'h07, 8'h00);
        pulse();
        pulse();
        check("pulses", 8'h03, pulse_cnt);
        rd(CDS_ADDR_SYNC_CTRL, 1, 8'h05, 8'h00);
        reset = 1'b1;
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        repeat (2) @(negedge core_clk);
        check("pattern three high", CDS_RST_PAT3_HIGH, test_pattern_three_high);
        check("pattern four low", CDS_RST_PAT4_LOW, test_pattern_four_low);
        check("buffer enable", 8'h00, {7'h00, sync_buffer_enable});
        rd(CDS_ADDR_SYNC_CTRL, 1, 8'h00, 8'h00);
        wr(CDS_ADDR_SYNC_CTRL, 8, 16'h0000);
        check("buffer enable", 8'h00, {7'h00, sync_buffer_enable});
        check("pending reads", 8'h00, 8'(exp_q.size()));
        end_of_test();
    end
endmodule : cds_top_test
